// >>> hdl/pccc_defs.vh
// constants for the synthesiser and clock pin control block
`ifndef PCCC_DEFS_VH
`define PCCC_DEFS_VH

// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define PCCC_IDX_CTRL 8'h3d
`define PCCC_IDX_POST 8'h3e
`define PCCC_IDX_STATUS 8'h3f

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define PCCC_RST_CTRL 8'h00
`define PCCC_RST_POST 8'h01

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define PCCC_SEL_HI 7
`define PCCC_SEL_LO 4
`define PCCC_EN_BIT 3
`define PCCC_PD_BIT 2
`define PCCC_FB_HI 1
`define PCCC_FB_LO 0

// ---------------------------------------------------------------
// source select codes
// ---------------------------------------------------------------
`define PCCC_SRC_GPIO 4'h0
`define PCCC_SRC_SYNTH 4'h1
`define PCCC_SRC_LOW 4'h2
`define PCCC_SRC_HIGH 4'h3
`define PCCC_SRC_XTAL1 4'h4
`define PCCC_SRC_XTAL2 4'h5
`define PCCC_SRC_XTAL4 4'h6
`define PCCC_SRC_XTAL8 4'h7
`define PCCC_SRC_TMR0 4'h8
`define PCCC_SRC_TMR1 4'h9
`define PCCC_SRC_TMR2 4'ha
`define PCCC_SRC_TMR3 4'hb

// ---------------------------------------------------------------
// feedback divisor codes and ratios
// ---------------------------------------------------------------
`define PCCC_FB_23 2'h0
`define PCCC_FB_27 2'h1
`define PCCC_FB_28 2'h2
`define PCCC_RATIO_23 5'h17
`define PCCC_RATIO_27 5'h1b
`define PCCC_RATIO_28 5'h1c

// ---------------------------------------------------------------
// divider chain
// ---------------------------------------------------------------
`define PCCC_DIV_STAGES 3

`endif

// >>> hdl/pccc_divider.v
// crystal divider chain producing divide by 2, 4 and 8
`timescale 1ns/100ps
`include "pccc_defs.vh"

module pccc_divider (
    // clock and reset
    input wire clock_in,
    input wire rst_in,
    // rising edge pulse of the synchronised crystal level
    input wire xtal_rise_in,
    // divided levels, bit 0 is divide by 2
    output wire [`PCCC_DIV_STAGES-1:0] div_out
);

    reg [`PCCC_DIV_STAGES-1:0] stage;
    wire [`PCCC_DIV_STAGES:0] carry;

    // ---------------------------------------------------------------
    // toggle stages
    // ---------------------------------------------------------------
    // synchronous counter form keeps every stage on the one clock
    assign carry[0] = xtal_rise_in;
    genvar i;
    generate
        for (i = 0; i < `PCCC_DIV_STAGES; i = i + 1) begin : g_stage
            assign carry[i+1] = carry[i] & stage[i];
            always @(posedge clock_in or posedge rst_in) begin
                if (rst_in) begin
                    stage[i] <= 1'b0;
                end else if (carry[i]) begin
                    stage[i] <= ~stage[i];
                end
            end
        end
    endgenerate

    assign div_out = stage;

endmodule

// >>> hdl/pccc_top.v
// synthesiser control register and clock output pin source selection
//
// How it works
// - code 0 releases pin to general I/O
// - code 1 drives synthesiser output on pin
// - code 2 holds low, code 3 high
// - codes 4-7 give crystal /1 /2 /4 /8
// - codes 8-B toggle on timer overflow
// - enable bit gates any clock onto pin
// - bits 1-0 hold feedback divisor code
// - first stage multiplies by ratio, halves
// - second stage divides by post divisor
// - codes 0,1,2 give ratios 23,27,28
`timescale 1ns/100ps
`include "pccc_defs.vh"

module pccc_top (
    // clock and reset
    input wire clock_in,
    input wire rst_in,
    // avalon-mm slave
    input wire [9:0] address_in,
    input wire read_in,
    input wire write_in,
    input wire [3:0] byteenable_in,
    input wire [31:0] writedata_in,
    output reg [31:0] readdata_out,
    output wire waitrequest_out,
    // clock sources
    input wire xtal_clock_in,
    input wire synth_clock_in,
    input wire [3:0] timer_overflow_in,
    // synthesiser controls
    output reg synth_power_down_out,
    output reg [4:0] synth_feedback_ratio_out,
    output reg [7:0] synth_post_divisor_out,
    // clock output pin
    output reg clock_output_pin_out,
    output reg clock_output_pin_oe_out,
    output reg gpio_release_out
);

    reg [7:0] ctrl;
    reg [7:0] post_div;
    reg ack;
    reg xtal_meta;
    reg xtal_sync;
    reg xtal_prev;
    reg synth_meta;
    reg synth_sync;
    reg timer_toggle;
    reg next_pin;
    reg next_oe;
    reg [4:0] next_ratio;
    reg [31:0] next_rdata;
    wire [`PCCC_DIV_STAGES-1:0] xtal_div;
    wire [3:0] sel;
    wire enabled;
    wire power_off;
    wire [1:0] fb_code;
    wire req;
    wire hit_ctrl;
    wire hit_post;
    wire hit_status;
    wire xtal_rise;

    assign sel = ctrl[`PCCC_SEL_HI:`PCCC_SEL_LO];
    assign enabled = ctrl[`PCCC_EN_BIT];
    assign power_off = ctrl[`PCCC_PD_BIT];
    assign fb_code = ctrl[`PCCC_FB_HI:`PCCC_FB_LO];

    // ---------------------------------------------------------------
    // bus decode and handshake
    // ---------------------------------------------------------------
    // one wait state: the access completes on the second edge of a request
    assign req = read_in | write_in;
    assign waitrequest_out = req & ~ack;
    assign hit_ctrl = (address_in == {`PCCC_IDX_CTRL, 2'b00});
    assign hit_post = (address_in == {`PCCC_IDX_POST, 2'b00});
    assign hit_status = (address_in == {`PCCC_IDX_STATUS, 2'b00});

    // acknowledge flag toggles high for one cycle per access
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ack <= 1'b0;
        end else begin
            ack <= req & ~ack;
        end
    end

    // read mux; unmapped addresses read as zero
    always @* begin
        next_rdata = 32'h00000000;
        if (hit_ctrl) begin
            next_rdata[7:0] = ctrl;
        end else if (hit_post) begin
            next_rdata[7:0] = post_div;
        end else if (hit_status) begin
            next_rdata[0] = clock_output_pin_out;
            next_rdata[1] = clock_output_pin_oe_out;
            next_rdata[2] = ~power_off;
            next_rdata[3] = timer_toggle;
        end
    end

    // read data captured in the wait cycle so it stands at the release edge
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            readdata_out <= 32'h00000000;
        end else if (read_in & ~ack) begin
            readdata_out <= next_rdata;
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    // writes land on the edge where waitrequest is low, low byte lane only
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl <= `PCCC_RST_CTRL;
            post_div <= `PCCC_RST_POST;
        end else if (write_in & ack & byteenable_in[0]) begin
            if (hit_ctrl) begin
                ctrl <= writedata_in[7:0];
            end
            if (hit_post) begin
                post_div <= writedata_in[7:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // synthesiser controls
    // ---------------------------------------------------------------
    // reserved code 3 falls back to the lowest ratio rather than an untested one
    always @* begin
        case (fb_code)
            `PCCC_FB_23: next_ratio = `PCCC_RATIO_23;
            `PCCC_FB_27: next_ratio = `PCCC_RATIO_27;
            `PCCC_FB_28: next_ratio = `PCCC_RATIO_28;
            default: next_ratio = `PCCC_RATIO_23;
        endcase
    end

    // the analogue loop does crystal*ratio/2 then /post divisor from these
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            synth_power_down_out <= 1'b0;
            synth_feedback_ratio_out <= `PCCC_RATIO_23;
            synth_post_divisor_out <= `PCCC_RST_POST;
        end else begin
            synth_power_down_out <= power_off;
            synth_feedback_ratio_out <= next_ratio;
            synth_post_divisor_out <= post_div;
        end
    end

    // ---------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------
    // both clock sources come from outside this domain; output is a
    // sampled replica, so edges jitter by up to one system clock period
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            xtal_meta <= 1'b0;
            xtal_sync <= 1'b0;
            xtal_prev <= 1'b0;
            synth_meta <= 1'b0;
            synth_sync <= 1'b0;
        end else begin
            xtal_meta <= xtal_clock_in;
            xtal_sync <= xtal_meta;
            xtal_prev <= xtal_sync;
            synth_meta <= synth_clock_in;
            synth_sync <= synth_meta;
        end
    end

    assign xtal_rise = xtal_sync & ~xtal_prev;

    pccc_divider u_divider (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .xtal_rise_in(xtal_rise),
        .div_out(xtal_div)
    );

    // ---------------------------------------------------------------
    // timer toggle
    // ---------------------------------------------------------------
    // toggle only on the selected timer; other overflows are ignored
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            timer_toggle <= 1'b0;
        end else if (sel[3:2] == 2'b10) begin
            if (timer_overflow_in[sel[1:0]]) begin
                timer_toggle <= ~timer_toggle;
            end
        end
    end

    // ---------------------------------------------------------------
    // pin source selection
    // ---------------------------------------------------------------
    always @* begin
        next_pin = 1'b0;
        next_oe = 1'b1;
        case (sel)
            `PCCC_SRC_GPIO: next_oe = 1'b0;
            `PCCC_SRC_SYNTH: next_pin = synth_sync & ~power_off;
            `PCCC_SRC_LOW: next_pin = 1'b0;
            `PCCC_SRC_HIGH: next_pin = 1'b1;
            `PCCC_SRC_XTAL1: next_pin = xtal_sync;
            `PCCC_SRC_XTAL2: next_pin = xtal_div[0];
            `PCCC_SRC_XTAL4: next_pin = xtal_div[1];
            `PCCC_SRC_XTAL8: next_pin = xtal_div[2];
            `PCCC_SRC_TMR0: next_pin = timer_toggle;
            `PCCC_SRC_TMR1: next_pin = timer_toggle;
            `PCCC_SRC_TMR2: next_pin = timer_toggle;
            `PCCC_SRC_TMR3: next_pin = timer_toggle;
            default: next_oe = 1'b0;
        endcase
        // with the enable clear nothing reaches the pin
        if (!enabled) begin
            next_pin = 1'b0;
            next_oe = 1'b0;
        end
    end

    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            clock_output_pin_out <= 1'b0;
            clock_output_pin_oe_out <= 1'b0;
            gpio_release_out <= 1'b1;
        end else begin
            clock_output_pin_out <= next_pin;
            clock_output_pin_oe_out <= next_oe;
            gpio_release_out <= (sel == `PCCC_SRC_GPIO);
        end
    end

endmodule

// >>> test/pccc_top_assertions.sv
// concurrent checks on the ports of the clock pin control block
`timescale 1ns/100ps
module pccc_top_assertions (
    // clock and reset
    input wire clock_in,
    input wire rst_in,
    // avalon-mm slave
    input wire [9:0] address_in,
    input wire read_in,
    input wire write_in,
    input wire [3:0] byteenable_in,
    input wire [31:0] writedata_in,
    input wire waitrequest_out,
    // synthesiser controls and pin
    input wire synth_power_down_out,
    input wire [4:0] synth_feedback_ratio_out,
    input wire [7:0] synth_post_divisor_out,
    input wire clock_output_pin_out,
    input wire clock_output_pin_oe_out,
    input wire gpio_release_out
);
    // ---------------------------------------------------------------
    // shadow registers rebuilt from completed bus writes
    // ---------------------------------------------------------------
    reg [7:0] ctrl;
    reg [7:0] post;
    wire wr_done = write_in && !waitrequest_out && byteenable_in[0];
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl <= 8'h00;
            post <= 8'h01;
        end else if (wr_done && address_in == 10'h0f4) begin
            ctrl <= writedata_in[7:0];
        end else if (wr_done && address_in == 10'h0f8) begin
            post <= writedata_in[7:0];
        end
    end
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    // a pending request is held off for exactly one cycle
    sequence s_req_waiting;
        (read_in || write_in) && waitrequest_out;
    endsequence
    a_wait_one: assert property (s_req_waiting |=> !waitrequest_out)
        else $error("request not answered in the second cycle");
    a_wait_first: assert property ($rose(read_in || write_in) |-> waitrequest_out)
        else $error("request answered in its first cycle");
    // pin outputs follow the control register one edge later
    a_gpio_release: assert property (
        gpio_release_out == ($past(ctrl[7:4]) == 4'h0) && !($past(ctrl[7:4]) == 4'h0
        && clock_output_pin_oe_out)) else $error("pin not released for code zero");
    a_fixed_level: assert property (
        $past(ctrl[3]) && $past(ctrl[7:5]) == 3'h1 |-> clock_output_pin_oe_out
        && clock_output_pin_out == $past(ctrl[4])) else $error("fixed level wrong");
    a_pin_disabled: assert property (
        !$past(ctrl[3]) |-> !clock_output_pin_oe_out && !clock_output_pin_out)
        else $error("clock on pin while output is off");
    a_synth_off: assert property (
        $past(ctrl[7:4]) == 4'h1 && $past(ctrl[2]) |-> !clock_output_pin_out)
        else $error("powered-off synthesiser reaches pin");
    a_reserved_off: assert property (
        $past(ctrl[7:6]) == 2'h3 |-> !clock_output_pin_oe_out && !clock_output_pin_out)
        else $error("reserved code drives pin");
    a_power_copy: assert property (synth_power_down_out == $past(ctrl[2]))
        else $error("power down output wrong");
    a_ratio_map: assert property (
        synth_feedback_ratio_out == ($past(ctrl[1:0]) == 2'h1 ? 5'h1b :
        $past(ctrl[1:0]) == 2'h2 ? 5'h1c : 5'h17)) else $error("ratio wrong");
    a_post_copy: assert property (
        $stable(post) |-> synth_post_divisor_out == $past(post))
        else $error("post divisor output wrong");
endmodule

// >>> test/tb_top.sv
// self-checking bench for the clock pin control block
`timescale 1ns/100ps
module tb_top;
    reg clock_in, rst_in, read_in, write_in;
    // source stimulus starts from its declared level so one process drives it
    reg xtal_clock_in = 1'b0, synth_clock_in = 1'b0;
    reg [9:0] address_in;
    reg [3:0] byteenable_in;
    reg [3:0] timer_overflow_in = 4'h0;
    reg [31:0] writedata_in, q;
    wire [31:0] readdata_out;
    wire waitrequest_out, synth_power_down_out, clock_output_pin_out;
    wire clock_output_pin_oe_out, gpio_release_out;
    wire [4:0] ratio;
    wire [7:0] post;
    integer n_fail = 0, samples_checked = 0, cyc = 0, t, c, e, n;
    pccc_top i_pccc_top (.clock_in(clock_in), .rst_in(rst_in), .address_in(address_in),
        .read_in(read_in), .write_in(write_in), .byteenable_in(byteenable_in),
        .writedata_in(writedata_in), .readdata_out(readdata_out),
        .waitrequest_out(waitrequest_out), .xtal_clock_in(xtal_clock_in),
        .synth_clock_in(synth_clock_in), .timer_overflow_in(timer_overflow_in),
        .synth_power_down_out(synth_power_down_out), .synth_feedback_ratio_out(ratio),
        .synth_post_divisor_out(post), .clock_output_pin_out(clock_output_pin_out),
        .clock_output_pin_oe_out(clock_output_pin_oe_out),
        .gpio_release_out(gpio_release_out));
    initial begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end
    // ---------------------------------------------------------------
    // slow source clocks, timer pulses of distinct periods, timeout
    // ---------------------------------------------------------------
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (cyc % 4 == 3) xtal_clock_in <= ~xtal_clock_in;
        if (cyc % 5 == 4) synth_clock_in <= ~synth_clock_in;
        for (t = 0; t < 4; t = t + 1) timer_overflow_in[t] <= (cyc % (16 << t) == 0);
        if (cyc == 12000) begin
            n_fail = n_fail + 1;
            complete_run;
        end
    end
    task complete_run;
        begin
            $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
            if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp, input integer tol);
        begin
            samples_checked = samples_checked + 1;
            if (tol == 0 ? got !== exp : (got + tol < exp || got > exp + tol)) begin
                n_fail = n_fail + 1;
                $display("MISMATCH %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // one avalon access, held until waitrequest is seen low
    task bus(input w, input [9:0] a, input [7:0] d);
        begin
            address_in <= a;
            writedata_in <= {24'h0, d};
            write_in <= w;
            read_in <= !w;
            @(posedge clock_in);
            while (waitrequest_out !== 1'b0) @(posedge clock_in);
            q = readdata_out;
            write_in <= 1'b0;
            read_in <= 1'b0;
            @(posedge clock_in);
        end
    endtask
    // pin changes over a fixed window; sampling aliases so counts are approximate
    task count_pin;
        reg p;
        begin
            n = 0;
            p = clock_output_pin_out;
            repeat (320) begin
                @(posedge clock_in);
                if (clock_output_pin_out !== p) n = n + 1;
                p = clock_output_pin_out;
            end
        end
    endtask
    initial begin
        {rst_in, read_in, write_in, address_in, writedata_in} = {1'b1, 44'h0};
        byteenable_in = 4'h1;
        repeat (20) @(posedge clock_in);
        rst_in <= 1'b0;
        @(posedge clock_in);
        bus(1'b0, 10'h0f4, 8'h00);
        chk(q, 32'h0, 0);
        chk({ratio, gpio_release_out, clock_output_pin_oe_out}, 7'h5e, 0);
        bus(1'b0, 10'h0f8, 8'h00);
        chk(q, 32'h1, 0);
        bus(1'b1, 10'h0f8, 8'h5a);
        byteenable_in <= 4'h0;
        bus(1'b1, 10'h0f8, 8'h33);
        byteenable_in <= 4'h1;
        bus(1'b1, 10'h100, 8'hff);
        bus(1'b0, 10'h100, 8'h00);
        chk(q, 32'h0, 0);
        bus(1'b0, 10'h0f8, 8'h00);
        chk({q[23:0], post}, 32'h5a5a, 0);
        for (c = 0; c < 4; c = c + 1) begin
            bus(1'b1, 10'h0f4, c[7:0]);
            bus(1'b0, 10'h0f4, 8'h00);
            chk(q, c, 0);
            chk(ratio, c == 1 ? 5'h1b : c == 2 ? 5'h1c : 5'h17, 0);
        end
        // every select code with the output both off and on
        for (c = 0; c < 16; c = c + 1) for (e = 0; e < 2; e = e + 1) begin
            bus(1'b1, 10'h0f4, {c[3:0], e[0], 3'h0});
            @(posedge clock_in);
            chk(clock_output_pin_oe_out, e == 1 && c > 0 && c < 12, 0);
            chk(gpio_release_out, c == 0, 0);
        end
        // toggle counts for synthesiser, crystal taps and timer overflows
        for (c = 1; c < 12; c = c + 1) if (c != 2 && c != 3) begin
            bus(1'b1, 10'h0f4, {c[3:0], 4'h8});
            repeat (8) @(posedge clock_in);
            count_pin;
            chk(n, c == 1 ? 64 : c < 8 ? 80 >> (c - 4) : 20 >> (c - 8), 1);
        end
        bus(1'b1, 10'h0f4, 8'h1c);
        repeat (8) @(posedge clock_in);
        count_pin;
        chk({n[7:0], synth_power_down_out, clock_output_pin_out}, 10'h2, 0);
        // status: pin low, driving, synthesiser unavailable; timer bit not predicted
        bus(1'b0, 10'h0fc, 8'h00);
        chk(q & 32'hfffffff7, 32'h2, 0);
        complete_run;
    end
endmodule
bind pccc_top pccc_top_assertions i_pccc_top_assertions (.clock_in(clock_in),
    .rst_in(rst_in), .address_in(address_in), .read_in(read_in), .write_in(write_in),
    .byteenable_in(byteenable_in), .writedata_in(writedata_in),
    .waitrequest_out(waitrequest_out), .synth_power_down_out(synth_power_down_out),
    .synth_feedback_ratio_out(synth_feedback_ratio_out),
    .synth_post_divisor_out(synth_post_divisor_out),
    .clock_output_pin_out(clock_output_pin_out),
    .clock_output_pin_oe_out(clock_output_pin_oe_out), .gpio_release_out(gpio_release_out));
